// ### host_bus_model.sv
// host processor model driving the sram-style port pins
// assumes mclk from the bench; pins change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    // clock
    input wire logic mclk,
    // pins towards the port
    output logic [7:1] addr,
    output logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    output logic read_strobe_low,
    output logic write_strobe_low,
    output logic chip_select_low,
    output logic fifo_sel
);
    initial begin
        addr = 7'h00;
        data_in = 16'h0000;
        read_strobe_low = 1'b1;
        write_strobe_low = 1'b1;
        chip_select_low = 1'b1;
        fifo_sel = 1'b0;
    end

    // one access: strobe low three cycles, then idle
    task automatic access(input logic wr, input logic cs_n,
        input logic fs, input logic [7:1] a, input logic [15:0] wd,
        output logic [15:0] rd);
        @(negedge mclk);
        addr = a;
        fifo_sel = fs;
        chip_select_low = cs_n;
        data_in = wr ? wd : ~data_in;
        read_strobe_low = wr;
        write_strobe_low = !wr;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rd = data_oe ? data_out : ~data_out;
        read_strobe_low = 1'b1;
        write_strobe_low = 1'b1;
        chip_select_low = 1'b1;
        data_in = ~data_in;
        addr = ~addr;
        repeat (2) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ### host_port_pkg.sv
// shared constants and types for the sram-style host port
// assumes a single 40 MHz clock domain
package host_port_pkg;

    localparam int ADDR_HI = 7;
    localparam int ADDR_LO = 1;
    localparam int DATA_W = 16;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int IRQ_SRC_W = 8;
    localparam int CSR_ADDR_W = 6;

    // address fields, in pin numbering A[7:1]
    localparam int REGION_HI = 7;
    localparam int REGION_LO = 6;
    localparam int HALF_BIT = 1;
    localparam logic [1:0] FIFO_REGION = 2'h0;

    // reset values
    localparam logic [1:0] RST_SYNC_INIT = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'h0,
        ACC_READ = 2'h1,
        ACC_WRITE = 2'h2
    } acc_state_t;

    typedef struct packed {
        logic active_high;
        logic open_drain;
        logic [IRQ_SRC_W-1:0] enable;
    } irq_cfg_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [CSR_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } csr_req_t;

    localparam csr_req_t CSR_REQ_RST = '0;

endpackage

// ### sram_host_port.sv
// sram-style host port: strobes, address decode, 16/32 pairing, irq pin
// assumes pins already synchronous to mclk; core answers csr reads
// in the same cycle as the request
`timescale 1ns/10ps
`default_nettype none
module sram_host_port (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // host pins
    input wire logic [7:1] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic chip_select_low,
    input wire logic fifo_sel,
    // interrupt pin
    output logic irq_out,
    output logic irq_oe,
    input wire host_port_pkg::irq_cfg_t irq_cfg,
    input wire logic [7:0] irq_events,
    // power
    input wire logic low_power,
    output logic wake_req,
    // csr access towards the core
    output host_port_pkg::csr_req_t csr_req,
    input wire logic [31:0] csr_rdata,
    // transmit words towards the core
    output logic [31:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // receive words from the core
    input wire logic [31:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // status
    output logic write_dropped
);

    //--------------------------------------------------
    // reset release
    //--------------------------------------------------
    logic [1:0] rsync_q;
    wire rst_n = rsync_q[1];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rsync_q <= host_port_pkg::RST_SYNC_INIT;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end

    //--------------------------------------------------
    // strobe qualification and decode
    //--------------------------------------------------
    host_port_pkg::acc_state_t state_q;
    host_port_pkg::acc_state_t state_d;
    logic armed_q;
    logic rx_full_q;
    logic [31:0] rx_word_q;
    logic [15:0] tx_lo_q;
    logic [15:0] csr_lo_q;
    logic [31:0] csr_hold_q;
    logic csr_fetch_q;
    logic tx_pend_q;
    logic [31:0] tx_word_q;
    logic fifo_in_ready;

    wire selected = ~chip_select_low;
    // both strobes low is illegal and taken as no access
    wire rd_lvl = selected & ~read_strobe_low & write_strobe_low;
    wire wr_lvl = selected & ~write_strobe_low & read_strobe_low;
    wire rd_start = (state_q == host_port_pkg::ACC_IDLE) & rd_lvl;
    wire wr_start = (state_q == host_port_pkg::ACC_IDLE) & wr_lvl;
    wire in_region = addr[host_port_pkg::REGION_HI:host_port_pkg::REGION_LO]
                     == host_port_pkg::FIFO_REGION;
    // upper lines ignored under fifo select
    wire to_fifo = fifo_sel | in_region;
    wire half_hi = addr[host_port_pkg::HALF_BIT];
    wire [5:0] csr_addr = addr[7:2];
    wire wr_ok = armed_q & ~low_power;
    wire csr_rd_go = rd_start & ~to_fifo & ~half_hi;
    wire csr_wr_go = wr_start & wr_ok & ~to_fifo & half_hi;
    wire rx_pop = rd_start & to_fifo & half_hi & rx_full_q;
    wire rx_take = rx_valid & rx_ready;
    wire tx_new = wr_start & wr_ok & to_fifo & half_hi;
    wire tx_push = tx_pend_q & fifo_in_ready;
    wire tx_room = ~tx_pend_q | tx_push;
    wire [31:0] tx_word_d = {data_in, tx_lo_q};
    wire irq_act = |(irq_events & irq_cfg.enable);
    wire irq_level = irq_cfg.active_high ? irq_act : ~irq_act;
    wire [15:0] rx_half = half_hi ? rx_word_q[31:16] : rx_word_q[15:0];
    wire [15:0] rd_value = to_fifo ? (rx_full_q ? rx_half : 16'h0000)
                                   : csr_hold_q[31:16];

    always_comb begin
        state_d = state_q;
        case (state_q)
            host_port_pkg::ACC_IDLE: begin
                if (rd_lvl) begin
                    state_d = host_port_pkg::ACC_READ;
                end else if (wr_lvl) begin
                    state_d = host_port_pkg::ACC_WRITE;
                end
            end
            host_port_pkg::ACC_READ: begin
                if (!rd_lvl) begin
                    state_d = host_port_pkg::ACC_IDLE;
                end
            end
            host_port_pkg::ACC_WRITE: begin
                if (!wr_lvl) begin
                    state_d = host_port_pkg::ACC_IDLE;
                end
            end
            default: begin
                state_d = host_port_pkg::ACC_IDLE;
            end
        endcase
    end

    //--------------------------------------------------
    // access state, pins and power
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= host_port_pkg::ACC_IDLE;
            data_oe <= 1'b0;
            wake_req <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            data_oe <= (state_d == host_port_pkg::ACC_READ);
            wake_req <= low_power & wr_start;
            if (low_power & wr_start) begin
                armed_q <= 1'b0;
            end else if (rd_start) begin
                armed_q <= 1'b1;
            end
        end
    end

    //--------------------------------------------------
    // read data and csr path
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= host_port_pkg::DATA_RST;
            csr_req <= host_port_pkg::CSR_REQ_RST;
            csr_fetch_q <= 1'b0;
            csr_hold_q <= host_port_pkg::WORD_RST;
            csr_lo_q <= host_port_pkg::DATA_RST;
        end else begin
            csr_req.rd <= csr_rd_go;
            csr_req.wr <= csr_wr_go;
            if (csr_rd_go | csr_wr_go) begin
                csr_req.addr <= csr_addr;
            end
            if (csr_wr_go) begin
                csr_req.wdata <= {data_in, csr_lo_q};
            end
            if (wr_start & ~to_fifo & ~half_hi) begin
                csr_lo_q <= data_in;
            end
            csr_fetch_q <= csr_rd_go;
            if (csr_fetch_q) begin
                csr_hold_q <= csr_rdata;
                data_out <= csr_rdata[15:0];
            end else if (rd_start & ~csr_rd_go) begin
                data_out <= rd_value;
            end
        end
    end

    //--------------------------------------------------
    // receive word holding register
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_q <= 1'b0;
            rx_ready <= 1'b0;
            rx_word_q <= host_port_pkg::WORD_RST;
        end else begin
            if (rx_take) begin
                rx_word_q <= rx_data;
            end
            rx_full_q <= rx_take | (rx_full_q & ~rx_pop);
            rx_ready <= ~(rx_take | (rx_full_q & ~rx_pop));
        end
    end

    //--------------------------------------------------
    // transmit pairing, drops new words while one waits on a full fifo
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_lo_q <= host_port_pkg::DATA_RST;
            tx_pend_q <= 1'b0;
            tx_word_q <= host_port_pkg::WORD_RST;
            write_dropped <= 1'b0;
        end else begin
            if (wr_start & wr_ok & to_fifo & ~half_hi) begin
                tx_lo_q <= data_in;
            end
            if (tx_new & tx_room) begin
                tx_word_q <= tx_word_d;
            end
            tx_pend_q <= (tx_new & tx_room) | (tx_pend_q & ~tx_push);
            write_dropped <= tx_new & ~tx_room;
        end
    end

    word_fifo #(
        .WIDTH(host_port_pkg::WORD_W),
        .DEPTH(host_port_pkg::FIFO_DEPTH)
    ) tx_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .in_data(tx_word_q),
        .in_valid(tx_pend_q),
        .in_ready(fifo_in_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    //--------------------------------------------------
    // interrupt pin
    //--------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            // open drain only ever pulls low
            irq_out <= irq_cfg.open_drain ? 1'b0 : irq_level;
            irq_oe <= irq_cfg.open_drain ? ~irq_level : 1'b1;
        end
    end

    //--------------------------------------------------
    // assertions
    //--------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_OE_READ: assert property (data_oe |-> $past(rd_lvl))
        else $error("data driven outside a read");
    AST_NO_CS: assert property (chip_select_low |=> !data_oe)
        else $error("data driven without chip select");
    AST_WAKE: assert property (low_power && wr_start |=> wake_req)
        else $error("missed wake write");
    AST_WAKE_CAUSE: assert property (wake_req |->
        $past(!chip_select_low && !write_strobe_low))
        else $error("wake without qualified write");
    AST_FIFO_SEL: assert property (fifo_sel && (rd_start || wr_start)
        |=> !csr_req.rd && !csr_req.wr)
        else $error("csr access under fifo select");
    AST_UPPER_IGN: assert property (fifo_sel && rd_start && rx_full_q
        && !addr[1] |=> data_out == $past(rx_word_q[15:0]))
        else $error("fifo read depends on upper address");
    AST_CSR_RD: assert property (rd_start && !to_fifo && !addr[1]
        |=> csr_req.rd ##1 !csr_req.rd)
        else $error("csr read not issued once");
    AST_CSR_WR: assert property (csr_req.wr |->
        $past(wr_lvl) && csr_req.wdata[31:16] == $past(data_in))
        else $error("bad csr write");
    AST_WORD32: assert property (csr_fetch_q
        |=> csr_hold_q == $past(csr_rdata))
        else $error("csr word not held");
    AST_IRQ_OD: assert property ($past(irq_cfg.open_drain)
        |-> !irq_out)
        else $error("open drain irq drove high");
    AST_ARMED: assert property (!armed_q && wr_start
        |=> !csr_req.wr && !$rose(tx_pend_q))
        else $error("write took effect before first read");
    AST_RESET: assert property ($rose(rst_n) |->
        state_q == host_port_pkg::ACC_IDLE && !data_oe)
        else $error("state not cleared by reset");

    COV_CSR_READ: cover property (csr_rd_go ##2 data_oe);
    COV_TX_PUSH: cover property (tx_push);
    COV_WAKE: cover property (wake_req);
    COV_RX_POP: cover property (rx_pop ##1 rx_ready);

endmodule
`default_nettype wire

// ### tb_sram_host_port.sv
// self-checking bench for the sram-style host port
// assumes host_bus_model on the pins; bench plays the core side
`timescale 1ns/10ps
`default_nettype none
module tb_sram_host_port;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic fs = 1'b0;
    logic cs_n = 1'b0;
    logic [7:1] addr;
    logic [15:0] data_in, data_out, rd;
    logic data_oe, read_strobe_low, write_strobe_low, chip_select_low;
    logic fifo_sel, irq_out, irq_oe, low_power, wake_req, tx_valid;
    logic tx_ready, rx_valid, rx_ready, write_dropped;
    host_port_pkg::irq_cfg_t irq_cfg;
    host_port_pkg::csr_req_t csr_req;
    logic [7:0] irq_events;
    logic [31:0] tx_data, rx_data;
    logic [31:0] q[$];
    logic [5:0] last_addr;
    logic [31:0] last_wdata;
    int failures = 0, check_count = 0, cycles = 0;
    int rd_cnt = 0, wr_cnt = 0, wake_cnt = 0, drop_cnt = 0, oe_cnt = 0;

    always #12.5 mclk = ~mclk;

    host_bus_model i_host_bus_model (
        .mclk(mclk), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .read_strobe_low(read_strobe_low),
        .write_strobe_low(write_strobe_low),
        .chip_select_low(chip_select_low), .fifo_sel(fifo_sel)
    );

    sram_host_port i_sram_host_port (
        .mclk(mclk), .nrst(nrst), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .read_strobe_low(read_strobe_low),
        .write_strobe_low(write_strobe_low),
        .chip_select_low(chip_select_low), .fifo_sel(fifo_sel),
        .irq_out(irq_out), .irq_oe(irq_oe), .irq_cfg(irq_cfg),
        .irq_events(irq_events), .low_power(low_power),
        .wake_req(wake_req), .csr_req(csr_req),
        .csr_rdata(32'hA5A5_1234), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready),
        .write_dropped(write_dropped)
    );

    // ----------------------------------------
    // core-side monitor and timeout
    // ----------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (data_oe === 1'b1) oe_cnt++;
        if (csr_req.rd === 1'b1) rd_cnt++;
        if (csr_req.wr === 1'b1) begin
            wr_cnt++;
            last_wdata = csr_req.wdata;
        end
        if (csr_req.rd === 1'b1 || csr_req.wr === 1'b1) begin
            last_addr = csr_req.addr;
        end
        if (wake_req === 1'b1) wake_cnt++;
        if (write_dropped === 1'b1) drop_cnt++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_data);
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic hw(input logic [7:1] a, input logic [15:0] d);
        i_host_bus_model.access(1'b1, cs_n, fs, a, d, rd);
    endtask

    task automatic hr(input logic [7:1] a);
        i_host_bus_model.access(1'b0, cs_n, fs, a, 16'h0000, rd);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (3) @(negedge mclk);
        check({data_oe, irq_oe, rx_ready, tx_valid, wake_req}, 0);
        check({csr_req.rd, csr_req.wr, csr_req.addr}, 0);
        check(csr_req.wdata, 0);
        @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
    endtask

    task automatic t_unarmed();
        hw(7'h22, 16'h1111);
        hw(7'h23, 16'h2222);
        check(wr_cnt, 0);
        check(data_oe, 0);
    endtask

    task automatic t_csr_rw();
        hr(7'h20);
        check(rd, 16'h1234);
        check(last_addr, 6'h10);
        check(data_oe, 0);
        hr(7'h21);
        check(rd, 16'hA5A5);
        check(rd_cnt, 1);
        hw(7'h22, 16'h5678);
        hw(7'h23, 16'h9ABC);
        check(wr_cnt, 1);
        check(last_wdata, 32'h9ABC_5678);
        check(last_addr, 6'h11);
    endtask

    task automatic t_cs_high();
        int oe_base;
        oe_base = oe_cnt;
        cs_n = 1'b1;
        hr(7'h20);
        hw(7'h22, 16'h0001);
        hw(7'h23, 16'h0002);
        cs_n = 1'b0;
        check(rd_cnt, 1);
        check(wr_cnt, 1);
        check(oe_cnt - oe_base, 0);
    endtask

    task automatic t_fifo();
        int q_base;
        q_base = q.size();
        fs = 1'b1;
        tx_ready = 1'b1;
        hw(7'h7C, 16'h1111);
        hw(7'h7D, 16'h2222);
        check(q.size() - q_base, 1);
        check(q[q_base], 32'h2222_1111);
        rx_data = 32'hCAFE_F00D;
        rx_valid = 1'b1;
        for (int k = 0; k < 8 && rx_ready !== 1'b1; k++) @(negedge mclk);
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        hr(7'h7E);
        check(rd, 16'hF00D);
        hr(7'h7F);
        check(rd, 16'hCAFE);
        check(rd_cnt, 1);
        check(wr_cnt, 1);
    endtask

    task automatic t_fill();
        int q_base;
        int drop_base;
        tx_ready = 1'b0;
        q_base = q.size();
        drop_base = drop_cnt;
        for (int k = 0; k < 36; k++) begin
            hw(7'h00, k[15:0]);
            hw(7'h01, k[15:0] + 16'h0100);
        end
        check((drop_cnt - drop_base) != 0, 1);
        for (int k = 0; k < 120; k++) begin
            @(negedge mclk);
            tx_ready = k[0];
        end
        check(q.size() - q_base + drop_cnt - drop_base, 36);
        check(tx_valid, 0);
        for (int k = 0; k < q.size() - q_base; k++) begin
            check(q[q_base + k], {k[15:0] + 16'h0100, k[15:0]});
        end
        fs = 1'b0;
    endtask

    task automatic t_irq();
        logic lvl;
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            irq_cfg = {i[0], i[1], 8'h04};
            irq_events = i[2] ? 8'h0C : 8'h0B;
            lvl = i[2] ~^ i[0];
            repeat (3) @(negedge mclk);
            check(irq_oe, i[1] ? !lvl : 1'b1);
            check(irq_out, i[1] ? 1'b0 : lvl);
        end
    endtask

    task automatic t_wake();
        low_power = 1'b1;
        cs_n = 1'b1;
        hw(7'h32, 16'h0000);
        check(wake_cnt, 0);
        cs_n = 1'b0;
        hw(7'h32, 16'h0000);
        check(wake_cnt, 1);
        low_power = 1'b0;
        hw(7'h22, 16'h3333);
        hw(7'h23, 16'h4444);
        check(wr_cnt, 1);
    endtask

    initial begin
        irq_cfg = {1'b1, 1'b0, 8'hFF};
        irq_events = 8'hFF;
        low_power = 1'b0;
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 32'h0000_0000;
        t_reset();
        t_unarmed();
        t_csr_rw();
        t_cs_high();
        t_fifo();
        t_fill();
        t_irq();
        t_wake();
        results();
    end
endmodule
`default_nettype wire

// ### word_fifo.sv
// synchronous fifo with a registered output stage
// assumes one clock and an active-low reset already synchronised
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // draining side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    wire push = in_valid & in_ready;
    wire load = (count_q != '0) & (~out_valid | out_ready);

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(load);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            count_q <= count_d;
            if (push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (load) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
                out_data <= mem_q[rd_ptr_q];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
